// ==== src/line_tx_regs.svh ====
// Purpose: offsets, field positions, reset values and pattern constants of the line transmitter
// Assumes: 4-bit register address, 8-bit register data
// Notes:   eight shaping segments make one bit period of mclk cycles
//
// Notes on behaviour
// - force-all-ones setting sends continuous ones whatever the framer supplies
// - any selected diagnostic pattern replaces framer data on the line output
// - with digital loopback on, the loopback path carries the diagnostic pattern too
// - global auto option sends AMI all ones while receive signal loss is reported
// - without signal loss, auto option leaves normal transmission untouched
// - loop-up generation repeats the five-bit pattern 00001
// - loop-down generation repeats the three-bit pattern 001
// - quasi-random sequence has period 2^20-1 in T1 and 2^15-1 in E1
// - each segment is a 7-bit code: 6-bit magnitude plus sign in the MSB
// - long-haul setting picks -7.5 dB, -15 dB or -22 dB waveform
// - long-haul pulse is 32 segments spread over four transmit bit periods
// - short-haul pulse is eight segments fixed by the equalizer code
// - equalizer code 01000..01100 picks cable range 0-133 up to 533-655 ft
// - arbitrary mode takes eight programmed 7-bit words, sign 1 means negative
// - arbitrary words reset to zero, so the line sees an all-zero pattern
`ifndef LINE_TX_REGS_SVH
`define LINE_TX_REGS_SVH

`define ADDR_CTRL       4'h0
`define ADDR_SHAPE      4'h1
`define ADDR_STATUS     4'h2
`define ADDR_SEG_BIT    3

`define CTRL_FORCE      0
`define CTRL_LOOP_UP    1
`define CTRL_LOOP_DOWN  2
`define CTRL_PRBS       3
`define CTRL_E1         4
`define CTRL_LOOPBACK   5
`define CTRL_AUTO       6
`define CTRL_LONG_HAUL  7

`define SHAPE_ARB       7
`define SHAPE_LBO_HI    6
`define SHAPE_LBO_LO    5
`define SHAPE_EQC_HI    4

`define CTRL_RST        8'h00
`define SHAPE_RST       8'h08
`define SEG_RST         7'h00

`define SEG_LAST        3'h7
`define LH_SPAN         4
`define LOOP_UP_PAT     5'h01
`define LOOP_UP_LAST    3'h4
`define LOOP_DOWN_PAT   3'h1
`define LOOP_DOWN_LAST  2'h2
`define LFSR_SEED       20'hFFFFF

`define EQC_0_133       5'h08
`define EQC_133_266     5'h09
`define EQC_266_399     5'h0A
`define EQC_399_533     5'h0B
`define EQC_533_655     5'h0C
`define SH_AMP_0        6'h1E
`define SH_AMP_1        6'h22
`define SH_AMP_2        6'h26
`define SH_AMP_3        6'h2A
`define SH_AMP_4        6'h2E

`define LBO_7P5DB       2'h0
`define LBO_15DB        2'h1
`define LH_AMP_7P5      6'h30
`define LH_AMP_15       6'h22
`define LH_AMP_22       6'h16
`define MAG_MAX         10'sh03F

`endif

// ==== src/line_tx_pkg.sv ====
// Purpose: types shared by the transmit line logic
// Assumes: constants live in line_tx_regs.svh
// Notes:   every module keeps its whole state in one packed struct
package line_tx_pkg;

    typedef enum logic [5:0] {
        SRC_FRAMER    = 6'h01,
        SRC_FORCE     = 6'h02,
        SRC_AUTO      = 6'h04,
        SRC_LOOP_UP   = 6'h08,
        SRC_LOOP_DOWN = 6'h10,
        SRC_PRBS      = 6'h20
    } tx_src_t;

    typedef logic [7:0][6:0] arb_words_t;

    typedef struct packed {
        logic [19:0] lfsr;
        logic [2:0]  up_cnt;
        logic [1:0]  down_cnt;
    } gen_state_t;

    typedef struct packed {
        logic [2:0] seg;
        logic [3:0] marks;
        logic [3:0] negs;
        logic       last_neg;
        logic [6:0] dac;
        logic       tip;
        logic       ring;
    } shaper_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] shape;
        arb_words_t arb;
        logic       loss_meta;
        logic       loss_sync;
        logic [2:0] seg;
        tx_src_t    src;
        logic       tx_bit;
        logic       step;
        logic       lb_data;
        logic [7:0] rdata;
    } main_state_t;

endpackage : line_tx_pkg

// ==== src/bit_stream_if.sv ====
// Purpose: one transmit bit per step between the controller and its helpers
// Assumes: step is a one-cycle pulse once per bit period
// Notes:   gen/ctl pair for the pattern source, drv/shp pair for the shaper
`timescale 1ns/1ps
interface bit_stream_if;
    logic step;
    logic bit_val;
    modport gen (input step, output bit_val);
    modport ctl (output step, input bit_val);
    modport drv (output step, output bit_val);
    modport shp (input step, input bit_val);
endinterface : bit_stream_if

// ==== src/tx_pattern_gen.sv ====
// Purpose: loop-up, loop-down and quasi-random bit sources
// Assumes: bus.step advances the selected and unselected sources alike
// Notes:   bit_val is combinational from state and the current selection
`timescale 1ns/1ps
`include "line_tx_regs.svh"
module tx_pattern_gen import line_tx_pkg::*; (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // control
    input  wire tx_src_t sel,
    input  wire logic    e1_mode,
    // stream
    bit_stream_if.gen    bus
);
    gen_state_t s_reg;
    gen_state_t s_next;
    logic       fb;

    always_comb begin
        s_next = s_reg;
        // T1 x^20+x^17+1, E1 x^15+x^14+1
        fb = e1_mode ? (s_reg.lfsr[14] ^ s_reg.lfsr[13]) : (s_reg.lfsr[19] ^ s_reg.lfsr[16]);
        if (bus.step) begin
            s_next.lfsr = {s_reg.lfsr[18:0], fb};
            s_next.up_cnt = (s_reg.up_cnt == `LOOP_UP_LAST) ? 3'h0 : s_reg.up_cnt + 3'h1;
            s_next.down_cnt = (s_reg.down_cnt == `LOOP_DOWN_LAST) ? 2'h0
                                                                  : s_reg.down_cnt + 2'h1;
        end
        case (sel)
            SRC_LOOP_UP:   bus.bit_val = 1'(`LOOP_UP_PAT >> (`LOOP_UP_LAST - s_reg.up_cnt));
            SRC_LOOP_DOWN: bus.bit_val = 1'(`LOOP_DOWN_PAT
                                            >> (`LOOP_DOWN_LAST - s_reg.down_cnt));
            SRC_PRBS:      bus.bit_val = e1_mode ? s_reg.lfsr[14] : s_reg.lfsr[19];
            default:       bus.bit_val = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_reg <= '{lfsr: `LFSR_SEED, up_cnt: 3'h0, down_cnt: 2'h0};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : tx_pattern_gen

// ==== src/tx_pulse_shaper.sv ====
// Purpose: AMI marks to 7-bit sign-magnitude DAC segment codes
// Assumes: bus.step arrives every eight mclk cycles
// Notes:   long haul sums the tails of the marks in the last four bit periods
`timescale 1ns/1ps
`include "line_tx_regs.svh"
module tx_pulse_shaper import line_tx_pkg::*; (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // shaping setup
    input  wire logic       long_haul,
    input  wire logic       arb_mode,
    input  wire logic [1:0] line_build_out_setting,
    input  wire logic [4:0] equalizer_code,
    input  wire arb_words_t arb,
    // stream and line
    bit_stream_if.shp       bus,
    output logic [6:0]      dac_code,
    output logic            line_out_tip,
    output logic            line_out_ring
);
    shaper_state_t s_reg;
    shaper_state_t s_next;
    logic signed [9:0] lvl;
    logic [9:0]        mag;
    logic [5:0]        sh_lvl;

    function automatic logic signed [9:0] lh_shape(input logic [4:0] idx, input logic [1:0] sel);
        logic [5:0] amp;
        amp = (sel == `LBO_7P5DB) ? `LH_AMP_7P5 : (sel == `LBO_15DB) ? `LH_AMP_15 : `LH_AMP_22;
        if (idx < 5'h08)      lh_shape = $signed({4'h0, amp});
        else if (idx < 5'h0C) lh_shape = -$signed({6'h00, amp[5:2]});
        else if (idx < 5'h10) lh_shape = -$signed({7'h00, amp[5:3]});
        else                  lh_shape = 10'sh000;
    endfunction : lh_shape

    function automatic logic [5:0] sh_amp(input logic [4:0] eqc);
        case (eqc)
            `EQC_0_133:   sh_amp = `SH_AMP_0;
            `EQC_133_266: sh_amp = `SH_AMP_1;
            `EQC_266_399: sh_amp = `SH_AMP_2;
            `EQC_399_533: sh_amp = `SH_AMP_3;
            `EQC_533_655: sh_amp = `SH_AMP_4;
            default:      sh_amp = `SH_AMP_0;
        endcase
    endfunction : sh_amp

    assign sh_lvl = sh_amp(equalizer_code);

    always_comb begin
        s_next = s_reg;
        lvl = 10'sh000;
        if (bus.step) begin
            s_next.seg = 3'h0;
            s_next.marks = {s_reg.marks[2:0], bus.bit_val};
            s_next.negs = {s_reg.negs[2:0], bus.bit_val & ~s_reg.last_neg};
            if (bus.bit_val) s_next.last_neg = ~s_reg.last_neg;
        end else begin
            s_next.seg = s_reg.seg + 3'h1;
        end
        if (long_haul) begin
            for (int a = 0; a < `LH_SPAN; a++) begin
                if (s_next.marks[a]) begin
                    lvl = s_next.negs[a]
                        ? lvl - lh_shape({a[1:0], s_next.seg}, line_build_out_setting)
                        : lvl + lh_shape({a[1:0], s_next.seg}, line_build_out_setting);
                end
            end
        end else if (s_next.marks[0]) begin
            if (arb_mode) begin
                lvl = $signed({4'h0, arb[s_next.seg][5:0]});
                if (arb[s_next.seg][6] ^ s_next.negs[0]) lvl = -lvl;
            end else begin
                if (s_next.seg < 3'h4) lvl = $signed({4'h0, sh_amp(equalizer_code)});
                else if (s_next.seg < 3'h6) lvl = -$signed({7'h00, sh_lvl[5:3]});
                if (s_next.negs[0]) lvl = -lvl;
            end
        end
        mag = (lvl < 0) ? 10'(-lvl) : 10'(lvl);
        if ($signed(mag) > `MAG_MAX) mag = 10'(`MAG_MAX);
        s_next.dac = {lvl < 0, mag[5:0]};
        if (mag == 10'h000) s_next.dac = 7'h00;
        s_next.tip = (mag != 10'h000) && !(lvl < 0);
        s_next.ring = (mag != 10'h000) && (lvl < 0);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dac_code = s_reg.dac;
    assign line_out_tip = s_reg.tip;
    assign line_out_ring = s_reg.ring;
endmodule : tx_pulse_shaper

// ==== src/line_tx_diag_pattern_lbo.sv ====
// Purpose: transmit line channel: diagnostic override, loopback tap, pulse shaping
// Assumes: framer_data is on mclk and held while framer_take is low
// Notes:   one bit period is eight mclk cycles, one per shaping segment
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "line_tx_regs.svh"
module line_tx_diag_pattern_lbo import line_tx_pkg::*; (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // framer side
    input  wire logic       framer_data,
    output logic            framer_take,
    // receiver status pin
    input  wire logic       receive_signal_loss,
    // loopback path
    output logic            loopback_data,
    // line side
    output logic [6:0]      dac_code,
    output logic            line_out_tip,
    output logic            line_out_ring
);
    main_state_t s_reg;
    main_state_t s_next;
    tx_src_t     pick;

    bit_stream_if gen_bus ();
    bit_stream_if shp_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic tx_src_t choose(input logic [7:0] ctrl, input logic loss);
        if (ctrl[`CTRL_FORCE])                  choose = SRC_FORCE;
        else if (ctrl[`CTRL_AUTO] && loss)      choose = SRC_AUTO;
        else if (ctrl[`CTRL_LOOP_UP])           choose = SRC_LOOP_UP;
        else if (ctrl[`CTRL_LOOP_DOWN])         choose = SRC_LOOP_DOWN;
        else if (ctrl[`CTRL_PRBS])              choose = SRC_PRBS;
        else                                    choose = SRC_FRAMER;
    endfunction : choose

    function automatic logic [7:0] read_word(input main_state_t st, input logic [3:0] a);
        if (a[`ADDR_SEG_BIT]) begin
            read_word = {1'b0, st.arb[a[2:0]]};
        end else begin
            case (a)
                `ADDR_CTRL:   read_word = st.ctrl;
                `ADDR_SHAPE:  read_word = st.shape;
                `ADDR_STATUS: read_word = {st.src, st.tx_bit, st.loss_sync};
                default:      read_word = 8'h00;
            endcase
        end
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next = s_reg;
        // two flops before the loss pin is used anywhere
        s_next.loss_meta = receive_signal_loss;
        s_next.loss_sync = s_reg.loss_meta;
        s_next.rdata = 8'h00;
        s_next.step = 1'b0;
        s_next.seg = s_reg.seg + 3'h1;
        pick = choose(s_reg.ctrl, s_reg.loss_sync);

        if (reg_wr) begin
            if (reg_addr[`ADDR_SEG_BIT]) begin
                s_next.arb[reg_addr[2:0]] = reg_wdata[6:0];
            end else begin
                case (reg_addr)
                    `ADDR_CTRL:  s_next.ctrl = reg_wdata;
                    `ADDR_SHAPE: s_next.shape = reg_wdata;
                    default:     s_next.ctrl = s_reg.ctrl;
                endcase
            end
        end
        if (reg_rd) begin
            s_next.rdata = read_word(s_reg, reg_addr);
        end

        if (s_reg.seg == `SEG_LAST) begin
            s_next.step = 1'b1;
            s_next.src = pick;
            case (pick)
                SRC_FRAMER:    s_next.tx_bit = framer_data;
                SRC_FORCE:     s_next.tx_bit = 1'b1;
                SRC_AUTO:      s_next.tx_bit = 1'b1;
                SRC_LOOP_UP:   s_next.tx_bit = gen_bus.bit_val;
                SRC_LOOP_DOWN: s_next.tx_bit = gen_bus.bit_val;
                SRC_PRBS:      s_next.tx_bit = gen_bus.bit_val;
                default:       s_next.tx_bit = framer_data;
            endcase
            // loopback sees the overridden bit, not the raw framer bit
            s_next.lb_data = s_next.tx_bit & s_reg.ctrl[`CTRL_LOOPBACK];
        end
        if (!s_reg.ctrl[`CTRL_LOOPBACK]) begin
            s_next.lb_data = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_reg.ctrl <= `CTRL_RST;
            s_reg.shape <= `SHAPE_RST;
            for (int i = 0; i < 8; i++) begin
                s_reg.arb[i] <= `SEG_RST;
            end
            s_reg.loss_meta <= 1'b0;
            s_reg.loss_sync <= 1'b0;
            s_reg.seg <= 3'h0;
            s_reg.src <= SRC_FRAMER;
            s_reg.tx_bit <= 1'b0;
            s_reg.step <= 1'b0;
            s_reg.lb_data <= 1'b0;
            s_reg.rdata <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers and outputs

    // the pattern sources advance after the bit is taken, so a selection change
    // continues from wherever each sequence stands rather than restarting it
    assign gen_bus.step = s_reg.step;
    assign shp_bus.step = s_reg.step;
    assign shp_bus.bit_val = s_reg.tx_bit;

    tx_pattern_gen u_gen (
        .mclk    (mclk),
        .reset_n (reset_n),
        .sel     (pick),
        .e1_mode (s_reg.ctrl[`CTRL_E1]),
        .bus     (gen_bus)
    );

    tx_pulse_shaper u_shp (
        .mclk                   (mclk),
        .reset_n                (reset_n),
        .long_haul              (s_reg.ctrl[`CTRL_LONG_HAUL]),
        .arb_mode               (s_reg.shape[`SHAPE_ARB]),
        .line_build_out_setting (s_reg.shape[`SHAPE_LBO_HI:`SHAPE_LBO_LO]),
        .equalizer_code         (s_reg.shape[`SHAPE_EQC_HI:0]),
        .arb                    (s_reg.arb),
        .bus                    (shp_bus),
        .dac_code               (dac_code),
        .line_out_tip           (line_out_tip),
        .line_out_ring          (line_out_ring)
    );

    assign reg_rdata = s_reg.rdata;
    assign framer_take = s_reg.step;
    assign loopback_data = s_reg.lb_data;
endmodule : line_tx_diag_pattern_lbo

// ==== test/line_tx_chk.sv ====
// Purpose: concurrent checks on the transmit line channel ports
// Assumes: register writes seen at the ports mirror the control and shape registers
// Notes:   settled means no register write for 40 cycles, so long-haul tails have died out
`timescale 1ns/1ps
module line_tx_chk (
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // framer, status and line
    input wire logic       framer_take,
    input wire logic       receive_signal_loss,
    input wire logic       loopback_data,
    input wire logic [6:0] dac_code,
    input wire logic       line_out_tip,
    input wire logic       line_out_ring
);
    logic [7:0] ctrl_reg;
    logic [7:0] shape_reg;
    logic [5:0] age_reg;
    logic [5:0] loss_reg;
    logic       arb_nz_reg;
    logic       settled;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_reg   <= 8'h00;
            shape_reg  <= 8'h08;
            age_reg    <= 6'h00;
            loss_reg   <= 6'h00;
            arb_nz_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 4'h0) ctrl_reg <= reg_wdata;
            if (reg_wr && reg_addr == 4'h1) shape_reg <= reg_wdata;
            if (reg_wr && reg_addr[3] && reg_wdata[6:0] != 7'h00) arb_nz_reg <= 1'b1;
            age_reg  <= reg_wr ? 6'h00 : (age_reg == 6'h3F ? age_reg : age_reg + 6'h01);
            loss_reg <= !receive_signal_loss ? 6'h00 :
                        (loss_reg == 6'h3F ? loss_reg : loss_reg + 6'h01);
        end
    end
    assign settled = age_reg >= 6'h28;

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    a_take_period: assert property (
        framer_take |=> !framer_take [*7] ##1 framer_take) else $error("bit period is not 8 cycles");
    a_tip_positive: assert property (
        line_out_tip == (!dac_code[6] && dac_code[5:0] != 6'h00)) else $error("tip disagrees with code");
    a_ring_negative: assert property (
        line_out_ring == (dac_code[6] && dac_code[5:0] != 6'h00)) else $error("ring disagrees with code");
    a_force_ones: assert property (
        framer_take && ctrl_reg[0] && !shape_reg[7] && settled |=> dac_code[5:0] != 6'h00)
        else $error("forced ones missing a mark");
    a_auto_on_loss: assert property (
        framer_take && ctrl_reg[6] && loss_reg >= 6'h14 && !shape_reg[7] && settled
        |=> (dac_code[5:0] != 6'h00) [*2]) else $error("auto ones missing a mark");
    a_force_loopback: assert property (
        framer_take && ctrl_reg[0] && ctrl_reg[5] && settled |-> loopback_data)
        else $error("loopback lost the forced ones");
    a_loopback_off: assert property (
        framer_take && !ctrl_reg[5] && settled |-> !loopback_data)
        else $error("loopback active while disabled");
    a_arb_reset_zero: assert property (
        framer_take && shape_reg[7] && !ctrl_reg[7] && !arb_nz_reg && settled
        |=> (dac_code == 7'h00) [*8]) else $error("arbitrary idle words not flat");
    a_shape_readback: assert property (
        reg_rd && reg_addr == 4'h1 |=> reg_rdata == $past(shape_reg))
        else $error("shape register readback wrong");

    c_force: cover property (framer_take && ctrl_reg[0] && settled);
    c_loopback: cover property (framer_take && ctrl_reg[5] && loopback_data);
    c_arb: cover property (framer_take && shape_reg[7] && settled);
endmodule : line_tx_chk

bind line_tx_diag_pattern_lbo line_tx_chk u_chk (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .framer_take(framer_take),
    .receive_signal_loss(receive_signal_loss), .loopback_data(loopback_data),
    .dac_code(dac_code), .line_out_tip(line_out_tip), .line_out_ring(line_out_ring)
);

// ==== test/line_monitor.sv ====
// Purpose: far-end line view: the segment-0 code of every transmitted bit
// Assumes: segment 0 of a bit is on the line the cycle after framer_take
// Notes:   got pulses one cycle when seg0 holds a fresh bit
`timescale 1ns/1ps
module line_monitor (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // transmitter line side
    input  wire logic       framer_take,
    input  wire logic [6:0] dac_code,
    // decoded view
    output logic            got,
    output logic [6:0]      seg0
);
    logic take_reg;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            take_reg <= 1'b0;
            got      <= 1'b0;
            seg0     <= 7'h00;
        end else begin
            take_reg <= framer_take;
            got      <= take_reg;
            if (take_reg) seg0 <= dac_code;
        end
    end
endmodule : line_monitor

// ==== test/tb.sv ====
// Purpose: self-checking bench for the transmit line channel
// Assumes: short haul unless a test sets long haul; patterns read at segment 0
// Notes:   pattern phase is free running, so checks look at period and recurrence
`timescale 1ns/1ps
module tb import line_tx_pkg::*;;
    typedef struct {logic [7:0] ctrl; logic loss; tx_src_t src; int per; int ones;} row_t;
    logic       mclk, reset_n, reg_wr, reg_rd, framer_take, got;
    logic       framer_data = 1'b0;
    logic       receive_signal_loss, loopback_data, line_out_tip, line_out_ring;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [6:0] dac_code, seg0;
    logic [6:0] s [60];
    logic [59:0] b;
    logic [1:0] fr_cnt = 2'd0;
    logic [5:0] sh_amp [5] = '{6'h1E, 6'h22, 6'h26, 6'h2A, 6'h2E};
    logic [5:0] lh_amp [4] = '{6'h30, 6'h22, 6'h16, 6'h16};
    int         num_errors, num_checks, m;
    row_t rows [14] = '{'{8'h00,0,SRC_FRAMER,4,30}, '{8'h40,0,SRC_FRAMER,4,30},
        '{8'h01,0,SRC_FORCE,1,60}, '{8'h21,0,SRC_FORCE,1,60}, '{8'h40,1,SRC_AUTO,1,60},
        '{8'h02,0,SRC_LOOP_UP,5,12}, '{8'h04,0,SRC_LOOP_DOWN,3,20},
        '{8'h24,0,SRC_LOOP_DOWN,3,20}, '{8'h08,0,SRC_PRBS,20,0}, '{8'h18,0,SRC_PRBS,15,0},
        '{8'h4F,1,SRC_FORCE,1,60}, '{8'h4E,1,SRC_AUTO,1,60},
        '{8'h06,0,SRC_LOOP_UP,5,12}, '{8'h0C,0,SRC_LOOP_DOWN,3,20}};

    line_tx_diag_pattern_lbo u_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .framer_data(framer_data), .framer_take(framer_take),
        .receive_signal_loss(receive_signal_loss), .loopback_data(loopback_data),
        .dac_code(dac_code), .line_out_tip(line_out_tip), .line_out_ring(line_out_ring));
    line_monitor u_line (.mclk(mclk), .reset_n(reset_n), .framer_take(framer_take),
        .dac_code(dac_code), .got(got), .seg0(seg0));

    always #12.5 mclk = ~mclk;
    // framer repeats 0011 so pass-through is recognisable
    always @(posedge mclk) if (framer_take) begin
        fr_cnt      <= fr_cnt + 2'd1;
        framer_data <= fr_cnt[1];
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd

    // sixty bits from the far end; optional loopback and AMI alternation checks
    task automatic collect(input logic lb, input logic ami);
        int t;
        logic last, seen;
        seen = 1'b0; last = 1'b0;
        for (int i = 0; i < 60; i++) begin
            t = 0;
            do begin @(negedge mclk); t++; end while (got !== 1'b1 && t < 20);
            if (got !== 1'b1) begin num_errors++; conclude(); end
            s[i] = seg0;
            b[i] = |seg0[5:0];
            if (lb) check("loopback", {7'h0, loopback_data}, {7'h0, b[i]});
            if (ami && b[i]) begin
                if (seen) check("ami sign", {7'h0, seg0[6]}, {7'h0, ~last});
                seen = 1'b1; last = seg0[6];
            end
        end
    endtask : collect

    task automatic prbs_check(input int len);
        int k;
        logic ok_a, ok_b;
        k = (len == 20) ? 17 : 14;
        ok_a = 1'b1; ok_b = 1'b1;
        for (int n = 0; n + len < 60; n++) begin
            if (b[n+len] !== (b[n+k] ^ b[n])) ok_a = 1'b0;
            if (b[n+len] !== (b[n+len-k] ^ b[n])) ok_b = 1'b0;
        end
        check("prbs recurrence", {7'h0, ok_a | ok_b}, 8'h01);
        check("prbs density", {7'h0, $countones(b) > 0 && $countones(b) < 60}, 8'h01);
    endtask : prbs_check

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic ok;
        mclk = 0; reset_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 4'h0; reg_wdata = 8'h00;
        receive_signal_loss = 0;
        num_errors = 0; num_checks = 0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            wr(4'h0, rows[i].ctrl);
            receive_signal_loss <= rows[i].loss;
            repeat (48) @(posedge mclk);
            rd(4'h2, rv);
            check("source", {2'b00, rv[7:2]}, {2'b00, rows[i].src});
            check("loss", {7'h0, rv[0]}, {7'h0, rows[i].loss});
            collect(rows[i].ctrl[5], 1'b1);
            if (rows[i].src == SRC_PRBS) prbs_check(rows[i].per);
            else begin
                check("ones", 8'($countones(b)), 8'(rows[i].ones));
                ok = 1'b1;
                for (int j = 0; j + rows[i].per < 60; j++) if (b[j] !== b[j+rows[i].per]) ok = 0;
                check("period", {7'h0, ok}, 8'h01);
            end
        end
        // mid-run reset, then reset values and refused places
        @(posedge mclk) reset_n <= 1'b0;
        receive_signal_loss <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(4'h0, rv); check("ctrl reset", rv, 8'h00);
        rd(4'h1, rv); check("shape reset", rv, 8'h08);
        for (int a = 8; a < 16; a++) begin rd(4'(a), rv); check("arb reset", rv, 8'h00); end
        wr(4'h3, 8'hFF); rd(4'h3, rv); check("unmapped", rv, 8'h00);
        wr(4'h1, 8'h88); wr(4'h0, 8'h01);
        repeat (48) @(posedge mclk);
        collect(1'b0, 1'b0);
        check("arb zero", 8'($countones(b)), 8'h00);
        wr(4'h8, 8'hA5); rd(4'h8, rv); check("arb word", rv, 8'h25);
        repeat (48) @(posedge mclk);
        collect(1'b0, 1'b1);
        check("arb segment", {2'b00, s[7][5:0]}, 8'h25);
        for (int k = 0; k < 5; k++) begin
            wr(4'h1, 8'h08 + 8'(k)); repeat (48) @(posedge mclk); collect(1'b0, 1'b1);
            check("short haul amp", {2'b00, s[5][5:0]}, {2'b00, sh_amp[k]});
        end
        wr(4'h0, 8'h82);
        for (int k = 0; k < 4; k++) begin
            wr(4'h1, {1'b0, 2'(k), 5'h08}); repeat (48) @(posedge mclk); collect(1'b0, 1'b0);
            m = -1;
            for (int i = 0; i < 10; i++) if (m < 0 && s[i][5:0] == lh_amp[k]) m = i;
            check("long haul peak", {7'h0, m >= 0}, 8'h01);
            if (m >= 0) begin
                check("tail size", {2'b00, s[m+1][5:0]}, {2'b00, lh_amp[k] >> 2});
                check("tail sign", {7'h0, s[m+1][6] ^ s[m][6]}, 8'h01);
                check("tail end", {1'b0, s[m+2]}, 8'h00);
                check("next peak", {2'b00, s[m+5][5:0]}, {2'b00, lh_amp[k]});
            end
        end
        conclude();
    end
endmodule : tb
